// >>> logic/twe_target.sv
// Two-wire serial EEPROM target: protocol engine, page buffer, array, write timer
// and a small Avalon-MM register slave.
// Assumes scl/sda and the address straps are asynchronous pins, sampled by clk.
`timescale 1ns/100ps

// Summary of operation
// RQ1: Data changes only while clock is low; changes while high are start or stop.
// RQ2: Data falling while clock high is a start; every command begins with one.
// RQ3: Data rising while clock high is a stop; it returns the device to idle.
// RQ4: Words are eight bits, MSB first; device acks each received word on clock nine.
// RQ5: Device is in standby after reset and after stop once writing has finished.
// RQ6: Controller recovers bus with start, nine clocks, start, then stop.
// RQ7: Device address word starts with pattern 1010 and ends with read/write select.
// RQ8: Small variant matches bits 3:2 to pins two and one; bit 1 is page zero.
// RQ9: Large variant matches bit 3 to pin two; bits 2:1 are page bits.
// RQ10: Byte write is address, word address, one data byte, each acked, then stop.
// RQ11: Stop after a write starts a 5 ms program; no acks meanwhile.
// RQ12: Page write sends up to sixteen bytes, each acked, closed by stop.
// RQ13: Writes advance only the low four address bits, wrapping inside the page.
// RQ14: Polling device address gets an ack only once programming has finished.
// RQ15: Address counter holds last accessed address plus one, kept between operations.
// RQ16: Reads wrap across the whole array; writes wrap within the page.
// RQ17: Current read sends byte at counter after address ack; controller nacks and stops.
// RQ18: Random read is dummy write of word address, repeated start, then read.
// RQ19: Each controller ack in a read advances the address and sends the next byte.
// RQ20: Incoming bits sampled on clock rise; outgoing bits change after clock fall.
// RQ21: Data line is open drain: pulled low or released.
// RQ22: Small variant uses a 9-bit word address, 32 pages of 16 bytes.
// RQ23: Large variant uses a 10-bit word address, 64 pages of 16 bytes.
// RQ24: Mismatched device address gets no ack; bus ignored until next start.
// RQ25: A parameter picks the 512 or 1024 byte variant.
module twe_target
    import twe_pkg::*;
#(
    parameter int unsigned CAP_BYTES = CAP_LARGE,
    parameter int unsigned NV_CYCLES = NV_PROGRAM_CYCLES
) (
    input wire logic clk,
    input wire logic arst_n,
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    input wire logic hw_addr_pin_two,
    input wire logic hw_addr_pin_one,
    input wire logic hw_addr_pin_zero,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest
);

    localparam logic SMALL = (CAP_BYTES == CAP_SMALL); // see RQ25

    twe_line_t line_s1_q, line_s2_q, line_s3_q;
    logic [1:0] hw_s1_q, hw_s2_q;
    twe_state_t state_q;
    logic [3:0] cnt_q;
    logic [7:0] shreg_q;
    logic [7:0] rd_byte_q;
    logic [ADDR_W-1:0] addr_q;
    logic [1:0] page_q;
    logic master_ack_q;
    logic sda_oe_n_q;
    logic sda_o_q;
    logic [7:0] buf_q [PAGE_BYTES];
    logic [PAGE_BYTES-1:0] mask_q;
    logic [7:0] mem_q [MEM_DEPTH];
    logic [NV_CNT_W-1:0] nv_cnt_q;
    logic ctrl_en_q;
    logic avs_waitrequest_q;
    logic [31:0] avs_readdata_q;

    logic scl_rise, scl_fall, start_det, stop_det;
    logic byte_fall, end_fall, busy, dev_match, commit;
    logic [ADDR_W-1:0] addr_inc;

    // Two flops per pin before any logic looks at the lines
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            line_s1_q <= '{scl: 1'b1, sda: 1'b1};
            line_s2_q <= '{scl: 1'b1, sda: 1'b1};
            line_s3_q <= '{scl: 1'b1, sda: 1'b1};
            hw_s1_q <= 2'h0;
            hw_s2_q <= 2'h0;
        end else begin
            line_s1_q <= '{scl: scl_i, sda: sda_i};
            line_s2_q <= line_s1_q;
            line_s3_q <= line_s2_q;
            hw_s1_q <= {hw_addr_pin_two, hw_addr_pin_one};
            hw_s2_q <= hw_s1_q;
        end
    end

    assign scl_rise = line_s2_q.scl & ~line_s3_q.scl;
    assign scl_fall = ~line_s2_q.scl & line_s3_q.scl;
    // Data edges with clock high in both samples are framing, not data (see RQ1)
    assign start_det = line_s2_q.scl & line_s3_q.scl & line_s3_q.sda & ~line_s2_q.sda; // see RQ2
    assign stop_det = line_s2_q.scl & line_s3_q.scl & ~line_s3_q.sda & line_s2_q.sda; // see RQ3
    assign byte_fall = scl_fall && (cnt_q == BIT_ACK);
    assign end_fall = scl_fall && (cnt_q == BIT_END);
    assign busy = (nv_cnt_q != '0);

    // Pattern plus strap compare; the small variant keeps bit 1 for paging
    always_comb begin
        dev_match = (shreg_q[7:4] == DEV_ID_PATTERN); // see RQ7
        if (SMALL) begin
            dev_match = dev_match && (shreg_q[3:2] == hw_s2_q); // see RQ8
        end else begin
            dev_match = dev_match && (shreg_q[3] == hw_s2_q[1]); // see RQ9
        end
        dev_match = dev_match && ctrl_en_q && !busy; // see RQ14
    end

    // Small variant never sets the top address bit, so reads wrap at 511
    assign addr_inc = SMALL ? {1'b0, addr_q[ADDR_W-2:0] + 9'h001}
                            : addr_q + 10'h001; // see RQ16 RQ22 RQ23
    assign commit = stop_det && (state_q == ST_WDATA) && (|mask_q); // see RQ11

    // Protocol engine
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            state_q <= ST_IDLE; // see RQ5
            cnt_q <= BIT_FIRST;
            shreg_q <= 8'h00;
            rd_byte_q <= 8'h00;
            addr_q <= '0;
            page_q <= 2'h0;
            master_ack_q <= 1'b0;
            sda_oe_n_q <= 1'b1;
        end else if (start_det) begin
            state_q <= ST_DEV; // see RQ2
            cnt_q <= BIT_FIRST;
            sda_oe_n_q <= 1'b1;
        end else if (stop_det) begin
            state_q <= ST_IDLE; // see RQ3
            cnt_q <= BIT_FIRST;
            sda_oe_n_q <= 1'b1;
        end else if (scl_rise && state_q != ST_IDLE && state_q != ST_IGNORE) begin
            if (cnt_q < BIT_ACK && state_q != ST_READ) begin
                shreg_q <= {shreg_q[6:0], line_s2_q.sda}; // see RQ4 RQ20
            end
            if (cnt_q == BIT_ACK && state_q == ST_READ) begin
                master_ack_q <= ~line_s2_q.sda; // see RQ19
            end
            if (cnt_q != BIT_END) begin
                cnt_q <= cnt_q + 4'h1;
            end
        end else if (byte_fall) begin
            unique case (state_q)
                ST_DEV: begin
                    if (dev_match) begin
                        sda_oe_n_q <= 1'b0; // see RQ4
                        master_ack_q <= 1'b1;
                        page_q <= SMALL ? {1'b0, shreg_q[1]} : shreg_q[2:1];
                        state_q <= shreg_q[0] ? ST_READ : ST_WADDR; // see RQ17
                    end else begin
                        state_q <= ST_IGNORE; // see RQ24 RQ11
                    end
                end
                ST_WADDR: begin
                    sda_oe_n_q <= 1'b0;
                    addr_q <= {page_q, shreg_q}; // see RQ18 RQ10
                    state_q <= ST_WDATA;
                end
                ST_WDATA: begin
                    sda_oe_n_q <= 1'b0; // see RQ12
                    addr_q[3:0] <= addr_q[3:0] + 4'h1; // see RQ13
                end
                ST_READ: begin
                    sda_oe_n_q <= 1'b1; // release so the controller can answer
                    addr_q <= addr_inc; // see RQ15 RQ16
                end
                ST_IDLE, ST_IGNORE: begin
                end
            endcase
        end else if (end_fall) begin
            cnt_q <= BIT_FIRST;
            if (state_q == ST_READ && master_ack_q) begin
                rd_byte_q <= mem_q[addr_q];
                sda_oe_n_q <= mem_q[addr_q][7]; // see RQ17 RQ19 RQ21
            end else begin
                sda_oe_n_q <= 1'b1;
                if (state_q == ST_READ) begin
                    state_q <= ST_IGNORE; // see RQ19
                end
            end
        end else if (scl_fall && state_q == ST_READ && cnt_q != BIT_FIRST
                     && cnt_q < BIT_ACK) begin
            sda_oe_n_q <= rd_byte_q[~cnt_q[2:0]]; // see RQ20 RQ21
        end
    end

    // Page buffer; only bytes actually received are programmed
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            mask_q <= '0;
            for (int i = 0; i < PAGE_BYTES; i++) begin
                buf_q[i] <= 8'h00;
            end
        end else if (start_det) begin
            mask_q <= '0;
        end else if (byte_fall && state_q == ST_WDATA) begin
            buf_q[addr_q[3:0]] <= shreg_q; // see RQ13
            mask_q[addr_q[3:0]] <= 1'b1;
        end
    end

    // Array contents survive everything but power, so no reset here
    always_ff @(posedge clk) begin
        if (commit) begin
            for (int i = 0; i < PAGE_BYTES; i++) begin
                if (mask_q[i]) begin
                    mem_q[{addr_q[ADDR_W-1:4], 4'(i)}] <= buf_q[i]; // see RQ12
                end
            end
        end
    end

    // Programming timer; while it runs no address is acknowledged
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            nv_cnt_q <= '0;
        end else if (commit) begin
            nv_cnt_q <= NV_CNT_W'(NV_CYCLES); // see RQ11
        end else if (busy) begin
            nv_cnt_q <= nv_cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            sda_o_q <= 1'b0;
        end else begin
            sda_o_q <= 1'b0; // see RQ21
        end
    end

    // Avalon slave: one wait state, request taken on the second edge
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            avs_waitrequest_q <= 1'b1;
            avs_readdata_q <= 32'h0000_0000;
            ctrl_en_q <= CTRL_EN_RESET;
        end else if ((avs_read || avs_write) && avs_waitrequest_q) begin
            avs_waitrequest_q <= 1'b0;
            avs_readdata_q <= 32'h0000_0000;
            if (avs_read) begin
                unique case (avs_address)
                    REG_CTRL: avs_readdata_q[CTRL_EN_BIT] <= ctrl_en_q;
                    REG_STATUS: begin
                        avs_readdata_q[STAT_BUSY_BIT] <= busy;
                        avs_readdata_q[STAT_STANDBY_BIT] <= (state_q == ST_IDLE)
                            && !busy; // see RQ5
                        avs_readdata_q[STAT_SELECTED_BIT] <= (state_q == ST_WADDR)
                            || (state_q == ST_WDATA) || (state_q == ST_READ);
                    end
                    REG_ADDRCNT: avs_readdata_q[ADDR_W-1:0] <= addr_q;
                    default: avs_readdata_q <= 32'h0000_0000;
                endcase
            end
        end else begin
            avs_waitrequest_q <= 1'b1;
            if (avs_write && !avs_waitrequest_q && avs_address == REG_CTRL
                && avs_byteenable[0]) begin
                ctrl_en_q <= avs_writedata[CTRL_EN_BIT];
            end
        end
    end

    assign sda_o = sda_o_q;
    assign sda_oe_n = sda_oe_n_q;
    assign avs_readdata = avs_readdata_q;
    assign avs_waitrequest = avs_waitrequest_q;

    a_start_enters_dev: assert property ( // see RQ2
        @(posedge clk) disable iff (!arst_n) start_det |=> state_q == ST_DEV && sda_oe_n_q
    ) else $error("start did not open a device address phase");

    a_stop_to_idle: assert property ( // see RQ3
        @(posedge clk) disable iff (!arst_n) stop_det |=> state_q == ST_IDLE && sda_oe_n_q
    ) else $error("stop did not return to idle");

    a_busy_gives_nack: assert property ( // see RQ11
        @(posedge clk) disable iff (!arst_n)
        byte_fall && state_q == ST_DEV && busy |=> sda_oe_n_q && state_q == ST_IGNORE
    ) else $error("address acknowledged during programming");

    a_commit_loads_timer: assert property ( // see RQ11
        @(posedge clk) disable iff (!arst_n)
        commit |=> nv_cnt_q == NV_CNT_W'(NV_CYCLES) ##1 nv_cnt_q == NV_CNT_W'(NV_CYCLES - 1)
    ) else $error("write timer not started by stop");

    a_write_page_wrap: assert property ( // see RQ13
        @(posedge clk) disable iff (!arst_n) byte_fall && state_q == ST_WDATA
        |=> addr_q[ADDR_W-1:4] == $past(addr_q[ADDR_W-1:4])
            && addr_q[3:0] == $past(addr_q[3:0]) + 4'h1 && !sda_oe_n_q
    ) else $error("write address left its page");

    a_bad_id_ignored: assert property ( // see RQ24
        @(posedge clk) disable iff (!arst_n)
        byte_fall && state_q == ST_DEV && shreg_q[7:4] != DEV_ID_PATTERN
        |=> state_q == ST_IGNORE && sda_oe_n_q
    ) else $error("foreign device address acknowledged");

    a_read_full_wrap: assert property ( // see RQ16
        @(posedge clk) disable iff (!arst_n)
        byte_fall && state_q == ST_READ && addr_q == (SMALL ? 10'h1FF : 10'h3FF)
        |=> addr_q == 10'h000
    ) else $error("read address did not wrap to zero");

    a_drive_after_fall: assert property ( // see RQ20
        @(posedge clk) disable iff (!arst_n)
        $changed(sda_oe_n_q) && !$past(start_det) && !$past(stop_det) |-> $past(scl_fall)
    ) else $error("data line changed away from a clock fall");

    a_ack_held_ninth: assert property ( // see RQ4
        @(posedge clk) disable iff (!arst_n)
        byte_fall && state_q == ST_WADDR |=> !sda_oe_n_q throughout (##[0:1000] end_fall)
    ) else $error("acknowledge not held through ninth clock");

endmodule

// >>> logic/twe_pkg.sv
// Package for the two-wire EEPROM target: constants, states and carrier types.
// Assumes a 20 MHz system clock that samples the serial lines.
package twe_pkg;

    // Capacity variants and word address widths
    localparam int unsigned CAP_SMALL = 512;
    localparam int unsigned CAP_LARGE = 1024;
    localparam int unsigned ADDR_W = 10;
    localparam int unsigned MEM_DEPTH = 1024;
    localparam int unsigned PAGE_BYTES = 16;

    // Fixed pattern in the upper nibble of the device address word
    localparam logic [3:0] DEV_ID_PATTERN = 4'hA;

    // Bit counter milestones within one nine-clock word
    localparam logic [3:0] BIT_FIRST = 4'h0;
    localparam logic [3:0] BIT_ACK = 4'h8;
    localparam logic [3:0] BIT_END = 4'h9;

    // Self-timed write: time in microseconds, clock in kHz
    localparam int unsigned NV_PROGRAM_TIME_US = 5000;
    localparam int unsigned CLK_FREQ_KHZ = 20000;
    localparam int unsigned NV_PROGRAM_CYCLES = NV_PROGRAM_TIME_US * CLK_FREQ_KHZ / 1000;
    localparam int unsigned NV_CNT_W = 20;

    // Avalon register map, byte addresses
    localparam logic [3:0] REG_CTRL = 4'h0;
    localparam logic [3:0] REG_STATUS = 4'h4;
    localparam logic [3:0] REG_ADDRCNT = 4'h8;
    localparam logic CTRL_EN_RESET = 1'b1;
    localparam int unsigned CTRL_EN_BIT = 0;
    localparam int unsigned STAT_BUSY_BIT = 0;
    localparam int unsigned STAT_STANDBY_BIT = 1;
    localparam int unsigned STAT_SELECTED_BIT = 2;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_DEV = 6'h02,
        ST_WADDR = 6'h04,
        ST_WDATA = 6'h08,
        ST_READ = 6'h10,
        ST_IGNORE = 6'h20
    } twe_state_t;

    // Serial clock and data sampled together
    typedef struct packed {
        logic scl;
        logic sda;
    } twe_line_t;

endpackage

// >>> tb/twe_ctl_model.sv
// Two-wire bus controller model: frames start, stop, bytes and acks on scl and sda.
// Assumes the bench wires sda as open drain with a pull-up and feeds back the resolved level.
`timescale 1ns/100ps
module twe_ctl_model (
    input wire logic clk,
    input wire logic sda_line,
    output logic scl = 1'b1,
    output logic sda_n = 1'b1,
    output logic link_v = 1'b0,
    output logic [31:0] link_d = 32'h0
);
    logic framed = 1'b0;

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask

    task automatic emit(input logic [31:0] v);
        link_d <= v;
        link_v <= 1'b1;
        tick(1);
        link_v <= 1'b0;
    endtask

    // Clock is left high after each bit so that start or stop may follow
    task automatic bit_io(input logic b, output logic r);
        scl <= 1'b0;
        tick(2);
        sda_n <= b;
        tick(2);
        scl <= 1'b1;
        tick(2);
        r = sda_line;
        tick(2);
    endtask

    // Clock stands still between frames; only a repeated start needs a low phase
    task automatic start_c();
        if (framed) begin
            scl <= 1'b0;
            tick(2);
            sda_n <= 1'b1;
            tick(2);
            scl <= 1'b1;
            tick(2);
        end
        sda_n <= 1'b0;
        framed = 1'b1;
        tick(4);
    endtask

    task automatic stop_c();
        scl <= 1'b0;
        tick(2);
        sda_n <= 1'b0;
        tick(2);
        scl <= 1'b1;
        tick(2);
        sda_n <= 1'b1;
        framed = 1'b0;
        tick(4);
    endtask

    task automatic put_byte(input logic [7:0] b);
        logic r;
        for (int i = 7; i >= 0; i--) bit_io(b[i], r);
        bit_io(1'b1, r);
        emit({31'h0, r});
    endtask

    // A low ack asks for the next byte, a high one ends the read
    task automatic get_byte(input logic nack);
        logic r;
        logic [7:0] d;
        for (int i = 7; i >= 0; i--) begin
            bit_io(1'b1, r);
            d[i] = r;
        end
        bit_io(nack, r);
        emit({24'h0, d});
    endtask
endmodule

// >>> tb/testbench.sv
// Self-checking bench for the two-wire EEPROM target, large variant, short program time.
// Assumes the controller model above and an open-drain sda with a pull-up.
`timescale 1ns/100ps
`define CHK(g, e) begin comparisons++; if ((g) !== (e)) begin error_cnt++; \
    $display("[ERR] %0t got %h exp %h", $time, (g), (e)); end end
module testbench
    import twe_pkg::*;
;
    localparam int unsigned NVC = 200;
    logic clk, arst_n, scl, sda_n, link_v, sda_o, sda_oe_n, sda_line;
    logic avs_read, avs_write, avs_waitrequest;
    logic av_v = 1'b0;
    logic hw_two = 1'b1;
    logic [3:0] avs_address;
    logic [31:0] link_d, av_d, avs_writedata, avs_readdata;
    logic [31:0] exp_q[$];
    logic [7:0] d[0:2];
    logic [7:0] pw[0:16];
    int error_cnt = 0;
    int comparisons = 0;

    assign sda_line = sda_n & (sda_oe_n | sda_o);

    twe_target #(.CAP_BYTES(CAP_LARGE), .NV_CYCLES(NVC)) dut_u (
        .clk(clk), .arst_n(arst_n), .scl_i(scl), .sda_i(sda_line), .sda_o(sda_o),
        .sda_oe_n(sda_oe_n), .hw_addr_pin_two(hw_two), .hw_addr_pin_one(1'b0),
        .hw_addr_pin_zero(1'b0), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hF),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));

    twe_ctl_model ctl_u (.clk(clk), .sda_line(sda_line), .scl(scl), .sda_n(sda_n),
        .link_v(link_v), .link_d(link_d));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [7:0] dev(input logic [1:0] p, input logic rw);
        return {DEV_ID_PATTERN, hw_two, p, rw};
    endfunction

    task automatic complete_run();
        $display("comparisons %0d error_cnt %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask

    // Holds the request until waitrequest is sampled low; only the watchdog ends a hang
    task automatic av(input logic rdn, input logic [3:0] a, input logic [31:0] wd);
        avs_read <= rdn;
        avs_write <= !rdn;
        avs_address <= a;
        avs_writedata <= wd;
        do begin
            @(posedge clk);
        end while (avs_waitrequest !== 1'b0);
        av_d <= avs_readdata;
        av_v <= rdn;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
        @(posedge clk);
        av_v <= 1'b0;
    endtask

    task automatic rreg(input logic [3:0] a, input logic [31:0] e);
        exp_q.push_back(e);
        av(1'b1, a, 32'h0);
    endtask

    task automatic tx(input logic [7:0] b, input logic nack);
        exp_q.push_back({31'h0, nack});
        ctl_u.put_byte(b);
    endtask

    task automatic rx(input logic [7:0] e, input logic nack);
        exp_q.push_back({24'h0, e});
        ctl_u.get_byte(nack);
    endtask

    always @(posedge clk) begin : mon
        logic [31:0] e;
        if (link_v === 1'b1 || av_v === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 32'hX;
            `CHK((link_v === 1'b1) ? link_d : av_d, e)
        end
    end

    initial begin
        repeat (20000) @(posedge clk);
        $display("[ERR] %0t watchdog expired", $time);
        error_cnt++;
        complete_run();
    end

    initial begin
        logic r;
        arst_n = 1'b0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_address = 4'h0;
        avs_writedata = 32'h0;
        void'($urandom(32'h9FCAFAB0));
        for (int i = 0; i < 17; i++) pw[i] = 8'($urandom);
        for (int i = 0; i < 3; i++) d[i] = 8'($urandom);
        repeat (16) @(posedge clk);
        hw_two <= 1'($urandom);
        arst_n <= 1'b1;
        repeat (4) @(posedge clk);
        rreg(REG_CTRL, 32'h1);
        rreg(REG_STATUS, 32'h2);
        rreg(REG_ADDRCNT, 32'h0);
        rreg(4'hC, 32'h0);
        $display("test done: reset");
        ctl_u.start_c();
        tx({DEV_ID_PATTERN, !hw_two, 3'h0}, 1'b1);
        ctl_u.start_c();
        tx({4'hB, hw_two, 3'h0}, 1'b1);
        ctl_u.stop_c();
        $display("test done: mismatch");
        ctl_u.start_c();
        tx(dev(2'h0, 1'b0), 1'b0);
        tx(8'h00, 1'b0);
        for (int i = 0; i < 3; i++) tx(d[i], 1'b0);
        ctl_u.stop_c();
        rreg(REG_STATUS, 32'h1);
        ctl_u.start_c();
        tx(dev(2'h3, 1'b0), 1'b1);
        repeat (NVC) @(posedge clk);
        ctl_u.start_c();
        tx(dev(2'h3, 1'b0), 1'b0);
        tx(8'hFE, 1'b0);
        for (int i = 0; i < 17; i++) tx(pw[i], 1'b0);
        ctl_u.stop_c();
        repeat (NVC + 20) @(posedge clk);
        rreg(REG_STATUS, 32'h2);
        $display("test done: write");
        ctl_u.start_c();
        tx(dev(2'h3, 1'b0), 1'b0);
        tx(8'hFE, 1'b0);
        ctl_u.start_c();
        tx(dev(2'h3, 1'b1), 1'b0);
        rx(pw[16], 1'b0);
        rx(pw[1], 1'b0);
        rx(d[0], 1'b1);
        ctl_u.stop_c();
        rreg(REG_ADDRCNT, 32'h1);
        ctl_u.start_c();
        tx(dev(2'h0, 1'b1), 1'b0);
        rx(d[1], 1'b1);
        ctl_u.stop_c();
        $display("test done: read");
        av(1'b0, REG_CTRL, 32'h0);
        rreg(REG_CTRL, 32'h0);
        ctl_u.start_c();
        tx(dev(2'h0, 1'b1), 1'b1);
        ctl_u.stop_c();
        av(1'b0, REG_CTRL, 32'h1);
        $display("test done: disable");
        ctl_u.start_c();
        tx(dev(2'h0, 1'b0), 1'b0);
        ctl_u.start_c();
        for (int i = 0; i < 9; i++) ctl_u.bit_io(1'b1, r);
        ctl_u.start_c();
        ctl_u.stop_c();
        ctl_u.start_c();
        tx(dev(2'h0, 1'b1), 1'b0);
        rx(d[2], 1'b1);
        ctl_u.stop_c();
        rreg(REG_ADDRCNT, 32'h3);
        $display("test done: recovery");
        repeat (2) @(posedge clk);
        complete_run();
    end
endmodule
